// ===== reset_sequencer_sim_counter_test.sv
// Self-checking bench for the reset sequencer, driven over AXI4-Lite and CPU strobes.
// Assumes rss_pin_model on the pin and rss_seq_props bound to the design.
`timescale 1ns/100ps
`default_nettype none
`include "rss_defines.vh"
module reset_sequencer_sim_counter_test;
   localparam int LONG = 64;
   localparam int WAKE = 96;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pin_n = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic power_up_pulse = 1'b0, undervoltage_reset = 1'b0, watchdog_timeout = 1'b0;
   logic [15:0] cpu_addr = 16'hFFFF;
   logic cpu_write = 1'b0, cpu_opcode_fetch = 1'b0, cpu_unmapped = 1'b0, pin_go = 1'b0;
   logic cpu_illegal_opcode = 1'b0, cpu_stop_exec = 1'b0, wake_event = 1'b0;
   logic monitor_mode = 1'b0, break_active = 1'b0, int_begin = 1'b0, int_serviced = 1'b0;
   logic i_mask_cleared = 1'b0, cpu_rti = 1'b0;
   logic [7:0] irq_req = 8'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic int_latched, set_i_mask, restore_regs, reset_pin_in, reset_pin_out, reset_pin_oe;
   logic [2:0] int_vector_sel;
   logic gpio_in, internal_reset_signal, osc_enable, clocks_run, bus_clk_en;
   logic watchdog_clk_en, watchdog_clear, watchdog_hold;
   logic [15:0] reset_vector;
   int miscompares = 0, total_checks = 0, oe_cnt = 0, ir_cnt = 0, oe_len = 0, ir_len = 0, n;
   logic [31:0] cause_exp [4] = '{32'h1 << `RSS_C_OPCODE, 32'h1 << `RSS_C_FETCH,
      32'h1 << `RSS_C_OPCODE, 32'h1 << `RSS_C_WDG};

   rss_reset_sequencer #(.PIN_MIN_CYC(13'h0008), .LONG_CYC(13'h0040), .LONG_WAKE(13'h0060)) dut (.*);
   rss_pin_model u_pin (.aclk(aclk), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
      .low_cycles(pin_n), .start(pin_go), .reset_pin_in(reset_pin_in));

   initial begin
      forever #25 aclk = ~aclk;
   end
   // Lengths of pin drive and internal reset, in cycles
   always @(posedge aclk) begin
      oe_cnt <= reset_pin_oe ? oe_cnt + 1 : 0;
      ir_cnt <= internal_reset_signal ? ir_cnt + 1 : 0;
      if (oe_cnt != 0 && !reset_pin_oe) oe_len <= oe_cnt;
      if (ir_cnt != 0 && !internal_reset_signal) ir_len <= ir_cnt;
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bvalid", 32'(s_axi_bvalid), 32'h1);
      chk("bresp", 32'(s_axi_bresp), 32'(er));
      @(posedge aclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rvalid", 32'(s_axi_rvalid), 32'h1);
      chk("rresp", 32'(s_axi_rresp), 32'(er));
      if (er == `RSS_OKAY) chk("rdata", s_axi_rdata, exp);
      @(posedge aclk);
   endtask
   // One-cycle strobe on the selected input
   task automatic fire(input int k);
      case (k)
         0: cpu_illegal_opcode <= 1'b1;
         1: begin
            cpu_opcode_fetch <= 1'b1;
            cpu_unmapped <= 1'b1;
         end
         2: cpu_stop_exec <= 1'b1;
         3: watchdog_timeout <= 1'b1;
         4: power_up_pulse <= 1'b1;
         5: cpu_unmapped <= 1'b1;
         6: int_begin <= 1'b1;
         7: int_serviced <= 1'b1;
         8: cpu_rti <= 1'b1;
         9: cpu_write <= 1'b1;
         default: wake_event <= 1'b1;
      endcase
      @(posedge aclk);
      {cpu_illegal_opcode, cpu_opcode_fetch, cpu_unmapped, cpu_stop_exec, watchdog_timeout,
         power_up_pulse, int_begin, int_serviced, cpu_rti, cpu_write, wake_event} <= 11'h000;
      @(posedge aclk);
   endtask
   // Give a reset time to start, then wait for it to end
   task automatic settle(input int lim);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while ((internal_reset_signal || n < 6) && n < lim);
      repeat (2) @(posedge aclk);
   endtask
   task automatic pin_low(input logic [7:0] c);
      pin_n <= c;
      pin_go <= 1'b1;
      @(posedge aclk);
      pin_go <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask
   task automatic wake_len(input logic [31:0] cfg, input int lo);
      axw(`RSS_OFF_CFG1, cfg, `RSS_OKAY);
      fire(2);
      @(posedge aclk);
      chk("clocks_run", 32'(clocks_run), 32'h0);
      fire(10);
      n = 2;
      while (!clocks_run && n < 400) begin
         @(posedge aclk);
         n++;
      end
      chk("wake", 32'(n >= lo && n <= lo + 4), 32'h1);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rdc(`RSS_OFF_CFG2, 32'h0, `RSS_OKAY);
      rdc(8'h40, 32'h0, `RSS_SLVERR);
      pin_low(8'h0C);
      chk("gpio", 32'(gpio_in), 32'h0);
      chk("internal_reset_signal", 32'(internal_reset_signal), 32'h0);
      fire(4);
      repeat (10) @(posedge aclk);
      chk("clk", 32'({clocks_run, osc_enable}), 32'h1);
      settle(400);
      chk("por_len", ir_len, LONG + 67);
      chk("por_oe", oe_len, 0);
      rdc(`RSS_OFF_CAUSE, 32'h1 << `RSS_C_POR, `RSS_OKAY);
      axw(`RSS_OFF_CAUSE, 32'hFF, `RSS_OKAY);
      axw(`RSS_OFF_CFG2, 32'h1, `RSS_OKAY);
      // Every internal source, with the pin enabled
      for (int k = 0; k < 4; k++) begin
         monitor_mode <= k[0];
         fire(k);
         repeat (6) @(posedge aclk);
         chk("vector", 32'(reset_vector), k[0] ? 32'hFEFE : 32'hFFFE);
         settle(300);
         chk("drive", oe_len, 32);
         chk("internal_reset_signal", ir_len, 67);
         rdc(`RSS_OFF_CAUSE, cause_exp[k], `RSS_OKAY);
         axw(`RSS_OFF_CAUSE, 32'hFF, `RSS_OKAY);
      end
      monitor_mode <= 1'b0;
      fire(5);
      settle(20);
      chk("data_fetch", 32'(internal_reset_signal), 32'h0);
      undervoltage_reset <= 1'b1;
      repeat (5) @(posedge aclk);
      undervoltage_reset <= 1'b0;
      repeat (10) @(posedge aclk);
      chk("uv_pin", 32'(reset_pin_oe), 32'h1);
      settle(400);
      rdc(`RSS_OFF_CAUSE, 32'h1 << `RSS_C_UV, `RSS_OKAY);
      axw(`RSS_OFF_CAUSE, 32'hFF, `RSS_OKAY);
      // Short pin pulse resets but must not set the flag; a long one sets it
      pin_low(8'h03);
      settle(200);
      rdc(`RSS_OFF_CAUSE, 32'h0, `RSS_OKAY);
      pin_low(8'h0E);
      chk("halt", 32'(internal_reset_signal), 32'h1);
      settle(200);
      rdc(`RSS_OFF_CAUSE, 32'h1 << `RSS_C_PIN, `RSS_OKAY);
      axw(`RSS_OFF_CAUSE, 32'hFF, `RSS_OKAY);
      wake_len(32'h3, 32);
      wake_len(32'h2, WAKE);
      rdc(`RSS_OFF_CAUSE, 32'h0, `RSS_OKAY);
      fire(9);
      axw(`RSS_OFF_SERVICE, 32'h5A, `RSS_OKAY);
      rdc(`RSS_OFF_SERVICE, 32'h0, `RSS_OKAY);
      axw(`RSS_OFF_BRKAUX, 32'h1, `RSS_OKAY);
      monitor_mode <= 1'b1;
      break_active <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("hold", 32'(watchdog_hold), 32'h1);
      axw(`RSS_OFF_BRKAUX, 32'h0, `RSS_OKAY);
      repeat (3) @(posedge aclk);
      chk("hold", 32'(watchdog_hold), 32'h0);
      {monitor_mode, break_active} <= 2'h0;
      irq_req <= 8'h0C;
      fire(6);
      chk("vec_sel", 32'(int_vector_sel), 32'h2);
      irq_req <= 8'h0D;
      fire(6);
      chk("vec_sel", 32'(int_vector_sel), 32'h2);
      fire(7);
      chk("latched", 32'(int_latched), 32'h0);
      irq_req <= 8'h00;
      fire(8);
      n = 0;
      while (!watchdog_clk_en && n < 4200) begin
         @(posedge aclk);
         n++;
      end
      chk("wdg_tick", 32'(watchdog_clk_en), 32'h1);
      test_done();
   end
endmodule
bind rss_reset_sequencer rss_seq_props #(.NUM_IRQ(NUM_IRQ), .IRQ_IDX_W(IRQ_IDX_W)) u_props (.*);
`default_nettype wire

// ===== rss_defines.vh
// Constants of the reset sequencer and prescale counter.
// Assumes inclusion by rss_reset_sequencer.v and by the bench.
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH
// Register byte offsets
`define RSS_OFF_CAUSE 8'h00
`define RSS_OFF_CFG1 8'h04
`define RSS_OFF_CFG2 8'h08
`define RSS_OFF_BRKAUX 8'h0C
`define RSS_OFF_SERVICE 8'h10
`define RSS_OFF_STATUS 8'h14
// Cause register bits
`define RSS_C_FETCH 1
`define RSS_C_OPCODE 2
`define RSS_C_WDG 4
`define RSS_C_UV 5
`define RSS_C_PIN 6
`define RSS_C_POR 7
// Configuration bits
`define RSS_CFG1_SHORT 0
`define RSS_CFG1_STOPEN 1
`define RSS_CFG2_PINEN 0
`define RSS_BRK_WDGDIS 0
// Reset values
`define RSS_CFG1_RST 8'h00
`define RSS_CFG2_RST 8'h00
`define RSS_BRK_RST 8'h00
// Reset vectors
`define RSS_VEC_NORMAL 16'hFFFE
`define RSS_VEC_MONITOR 16'hFEFE
`define RSS_SERVICE_ADDR 16'hFFFF
// Timing in base clock cycles
`define RSS_LONG_CYC 13'h1000
`define RSS_DRIVE_CYC 13'h0020
`define RSS_HOLD_CYC 13'h0020
`define RSS_TAIL_CYC 13'h0003
`define RSS_SHORT_WAKE 13'h0020
`define RSS_LONG_WAKE 13'h1000
// Prescale stages cleared by a watchdog service
`define RSS_SVC_HI 11
`define RSS_SVC_LO 4
// AXI responses
`define RSS_OKAY 2'h0
`define RSS_SLVERR 2'h2
// Sequencer states
`define RSS_S_IDLE 3'h0
`define RSS_S_LONG 3'h1
`define RSS_S_DRIVE 3'h2
`define RSS_S_HOLD 3'h3
`define RSS_S_TAIL 3'h4
`define RSS_S_EXT 3'h5
`define RSS_S_STOP 3'h6
`define RSS_S_WAKE 3'h7
`endif

// ===== rss_pin_model.sv
// Far-side model of the reset pin: internal pull-up plus an outside party.
// Assumes the sequencer's pin output and enable; returns the resolved level.
`timescale 1ns/100ps
`default_nettype none
module rss_pin_model (
   // Clock
   input wire logic aclk,
   // Sequencer side of the pin
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   // Outside party control
   input wire logic [7:0] low_cycles,
   input wire logic start,
   // Resolved pin level
   output logic reset_pin_in
);
   logic [7:0] left = 8'h00;
   // Outside party holds the pin low for a set count of cycles
   always @(posedge aclk) begin
      if (start) begin
         left <= low_cycles;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   // Pull-up wins whenever nobody drives low, so a released pin never floats
   assign reset_pin_in = ((reset_pin_oe && !reset_pin_out) || left != 8'h00) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== rss_reset_sequencer.v
// Reset sequencer, prescale counter and interrupt latch of the system unit.
// Assumes aclk is the base clock; CPU strobes are one-cycle pulses on aclk.
//
// Behaviour
// - Every reset asserts internal reset, selects vector
// - Internal resets clear prescaler; pin reset does not
// - Each cause sets its own flag
// - Enabled pin low halts; long enough sets flag
// - Pin is plain input until enable bit set
// - Power-up/undervoltage hold pin low 4096+32 cycles
// - Internal sources drive pin 32, hold 32
// - Recovery totals 4163 or 67 cycles
// - Power-up: reset, oscillator on, clocks stopped
// - Watchdog overflow resets, sets flag
// - Service write clears watchdog and stages 12-5
// - Watchdog clock every 4096 cycles when not serviced
// - Break in monitor with disable bit holds watchdog
// - Undefined instruction sets flag and resets
// - Stop with stop disabled is bad opcode
// - Only opcode fetch from unmapped address resets
// - Undervoltage counts 4096 after recovery, pin low
// - Twelve stages plus overflow stage clocking watchdog
// - Stop clears prescaler; wake delay 32 or 4096
// - Prescaler free-runs after reset states
// - Interrupt latched and held until serviced or mask cleared
// - Entry sets mask; return restores registers
// - Bus clock is base clock divided by four
`include "rss_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module rss_reset_sequencer #(
   parameter PIN_MIN_CYC = 13'h0008,
   parameter LONG_CYC = `RSS_LONG_CYC,
   parameter LONG_WAKE = `RSS_LONG_WAKE,
   parameter NUM_IRQ = 8,
   parameter IRQ_IDX_W = 3
) (
   // Clock and bus reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Reset sources
   input wire power_up_pulse,
   input wire undervoltage_reset,
   input wire watchdog_timeout,
   // CPU signals
   input wire [15:0] cpu_addr,
   input wire cpu_write,
   input wire cpu_opcode_fetch,
   input wire cpu_unmapped,
   input wire cpu_illegal_opcode,
   input wire cpu_stop_exec,
   input wire wake_event,
   input wire monitor_mode,
   input wire break_active,
   // Interrupts
   input wire [NUM_IRQ-1:0] irq_req,
   input wire int_begin,
   input wire int_serviced,
   input wire i_mask_cleared,
   input wire cpu_rti,
   output reg int_latched,
   output reg [IRQ_IDX_W-1:0] int_vector_sel,
   output reg set_i_mask,
   output reg restore_regs,
   // Reset pin
   input wire reset_pin_in,
   output reg reset_pin_out,
   output reg reset_pin_oe,
   output reg gpio_in,
   // Status to the chip
   output reg internal_reset_signal,
   output reg [15:0] reset_vector,
   output reg osc_enable,
   output reg clocks_run,
   output reg bus_clk_en,
   output reg watchdog_clk_en,
   output reg watchdog_clear,
   output reg watchdog_hold
);
   reg [2:0] state;
   reg [12:0] seq_cnt;
   reg [12:0] ext_cnt;
   reg [11:0] prescale;
   reg [1:0] bus_div;
   reg pin_s1, pin_s2;
   reg wdg_s1, wdg_s2, wdg_s3;
   reg [7:0] cause;
   reg [7:0] cfg1, cfg2, brkaux;
   reg aw_hold, w_hold;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [IRQ_IDX_W-1:0] next_sel;
   reg next_found;
   integer i;

   wire pin_en = cfg2[`RSS_CFG2_PINEN];
   wire stop_en = cfg1[`RSS_CFG1_STOPEN];
   wire running = (state == `RSS_S_IDLE);
   // A rising edge only, so a stuck overflow level cannot loop resets
   wire wdg_evt = wdg_s2 & ~wdg_s3 & ~watchdog_hold;
   wire bad_op = running & (cpu_illegal_opcode | (cpu_stop_exec & ~stop_en));
   wire bad_fetch = running & cpu_opcode_fetch & cpu_unmapped;
   wire go_long = power_up_pulse | undervoltage_reset;
   wire in_long = (state == `RSS_S_LONG) | (state == `RSS_S_DRIVE);
   wire go_int = ~go_long & ~in_long & (wdg_evt | bad_op | bad_fetch);
   // Our own drive of the pin is not seen as an outside reset
   wire ext_low = pin_en & ~pin_s2 & ~reset_pin_oe;
   wire go_stop = running & cpu_stop_exec & stop_en;
   wire clr_pre = go_long | go_int | go_stop;
   wire wake_done = seq_cnt == (cfg1[`RSS_CFG1_SHORT] ? `RSS_SHORT_WAKE - 13'h0001
                                : LONG_WAKE - 13'h0001);
   wire do_write = aw_hold & w_hold & ~s_axi_bvalid;
   wire svc_bus = do_write & (aw_addr == `RSS_OFF_SERVICE);
   wire svc_cpu = cpu_write & (cpu_addr == `RSS_SERVICE_ADDR);
   wire service = svc_bus | svc_cpu;
   wire pin_flag = (state == `RSS_S_EXT) & (ext_cnt == PIN_MIN_CYC - 13'h0001);

   // Synchronisers; first stages feed only second stages
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
         wdg_s1 <= 1'b0;
         wdg_s2 <= 1'b0;
         wdg_s3 <= 1'b0;
      end else begin
         pin_s1 <= reset_pin_in;
         pin_s2 <= pin_s1;
         wdg_s1 <= watchdog_timeout;
         wdg_s2 <= wdg_s1;
         wdg_s3 <= wdg_s2;
      end
   end

   // Reset sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         state <= `RSS_S_IDLE;
         seq_cnt <= 13'h0000;
         ext_cnt <= 13'h0000;
      end else if (go_long) begin
         // Undervoltage keeps the count at zero until the supply recovers
         state <= `RSS_S_LONG;
         seq_cnt <= 13'h0000;
      end else if (go_int) begin
         state <= `RSS_S_DRIVE;
         seq_cnt <= 13'h0000;
      end else if (ext_low & (running | state == `RSS_S_STOP | state == `RSS_S_WAKE)) begin
         state <= `RSS_S_EXT;
         ext_cnt <= 13'h0000;
      end else begin
         case (state)
            `RSS_S_IDLE: begin
               if (go_stop) begin
                  state <= `RSS_S_STOP;
               end
            end
            `RSS_S_LONG: begin
               if (seq_cnt == LONG_CYC - 13'h0001) begin
                  state <= `RSS_S_DRIVE;
                  seq_cnt <= 13'h0000;
               end else begin
                  seq_cnt <= seq_cnt + 13'h0001;
               end
            end
            `RSS_S_DRIVE: begin
               if (seq_cnt == `RSS_DRIVE_CYC - 13'h0001) begin
                  state <= `RSS_S_HOLD;
                  seq_cnt <= 13'h0000;
               end else begin
                  seq_cnt <= seq_cnt + 13'h0001;
               end
            end
            `RSS_S_HOLD: begin
               if (seq_cnt == `RSS_HOLD_CYC - 13'h0001) begin
                  state <= `RSS_S_TAIL;
                  seq_cnt <= 13'h0000;
               end else begin
                  seq_cnt <= seq_cnt + 13'h0001;
               end
            end
            `RSS_S_TAIL: begin
               if (seq_cnt == `RSS_TAIL_CYC - 13'h0001) begin
                  state <= `RSS_S_IDLE;
                  seq_cnt <= 13'h0000;
               end else begin
                  seq_cnt <= seq_cnt + 13'h0001;
               end
            end
            `RSS_S_EXT: begin
               if (!ext_low) begin
                  state <= `RSS_S_HOLD;
                  seq_cnt <= 13'h0000;
               end else if (ext_cnt != PIN_MIN_CYC) begin
                  ext_cnt <= ext_cnt + 13'h0001;
               end
            end
            `RSS_S_STOP: begin
               if (wake_event) begin
                  state <= `RSS_S_WAKE;
                  seq_cnt <= 13'h0000;
               end
            end
            `RSS_S_WAKE: begin
               if (wake_done) begin
                  state <= `RSS_S_IDLE;
               end else begin
                  seq_cnt <= seq_cnt + 13'h0001;
               end
            end
            default: begin
               state <= `RSS_S_IDLE;
            end
         endcase
      end
   end

   // Prescale counter; sampling on the rising edge stands in for the falling one
   always @(posedge aclk) begin
      if (!aresetn) begin
         prescale <= 12'h000;
         watchdog_clk_en <= 1'b0;
      end else if (clr_pre) begin
         prescale <= 12'h000;
         watchdog_clk_en <= 1'b0;
      end else begin
         prescale <= prescale + 12'h001;
         watchdog_clk_en <= (prescale == 12'hFFF);
         if (service) begin
            prescale[`RSS_SVC_HI:`RSS_SVC_LO] <= 8'h00;
         end
      end
   end

   // Outputs of the sequencer and clock control
   always @(posedge aclk) begin
      if (!aresetn) begin
         internal_reset_signal <= 1'b0;
         reset_pin_out <= 1'b1;
         reset_pin_oe <= 1'b0;
         gpio_in <= 1'b1;
         reset_vector <= `RSS_VEC_NORMAL;
         osc_enable <= 1'b1;
         clocks_run <= 1'b1;
         bus_div <= 2'h0;
         bus_clk_en <= 1'b0;
         watchdog_clear <= 1'b0;
         watchdog_hold <= 1'b0;
      end else begin
         internal_reset_signal <= ~running & (state != `RSS_S_STOP)
                                  & (state != `RSS_S_WAKE);
         reset_vector <= monitor_mode ? `RSS_VEC_MONITOR : `RSS_VEC_NORMAL;
         // Pin drive only while the pin has its reset role
         reset_pin_out <= 1'b0;
         reset_pin_oe <= pin_en & in_long;
         gpio_in <= pin_s2;
         osc_enable <= (state != `RSS_S_STOP);
         clocks_run <= running;
         bus_div <= running ? bus_div + 2'h1 : 2'h0;
         bus_clk_en <= running & (bus_div == 2'h3);
         watchdog_clear <= service;
         watchdog_hold <= break_active & monitor_mode & brkaux[`RSS_BRK_WDGDIS];
      end
   end

   // Interrupt arbitration: lowest index wins
   always @* begin
      next_sel = {IRQ_IDX_W{1'b0}};
      next_found = 1'b0;
      for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
         if (irq_req[i]) begin
            next_sel = i[IRQ_IDX_W-1:0];
            next_found = 1'b1;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn || internal_reset_signal) begin
         int_latched <= 1'b0;
         int_vector_sel <= {IRQ_IDX_W{1'b0}};
         set_i_mask <= 1'b0;
         restore_regs <= 1'b0;
      end else begin
         set_i_mask <= 1'b0;
         restore_regs <= cpu_rti;
         if (int_begin && !int_latched && next_found) begin
            int_latched <= 1'b1;
            int_vector_sel <= next_sel;
            set_i_mask <= 1'b1;
         end else if (int_serviced || i_mask_cleared) begin
            int_latched <= 1'b0;
         end
      end
   end

   // Cause flags: hardware set wins over a software clear in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         cause <= 8'h00;
      end else begin
         if (do_write && aw_addr == `RSS_OFF_CAUSE && w_strb[0]) begin
            cause <= cause & ~w_data[7:0];
         end
         if (power_up_pulse) begin
            cause[`RSS_C_POR] <= 1'b1;
         end
         if (undervoltage_reset) begin
            cause[`RSS_C_UV] <= 1'b1;
         end
         if (~go_long & ~in_long & wdg_evt) begin
            cause[`RSS_C_WDG] <= 1'b1;
         end
         if (~go_long & ~in_long & bad_op) begin
            cause[`RSS_C_OPCODE] <= 1'b1;
         end
         if (~go_long & ~in_long & bad_fetch) begin
            cause[`RSS_C_FETCH] <= 1'b1;
         end
         if (pin_flag) begin
            cause[`RSS_C_PIN] <= 1'b1;
         end
      end
   end

   // AXI4-Lite write channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RSS_OKAY;
         cfg1 <= `RSS_CFG1_RST;
         cfg2 <= `RSS_CFG2_RST;
         brkaux <= `RSS_BRK_RST;
      end else begin
         s_axi_awready <= ~aw_hold & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_hold & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RSS_OKAY;
            case (aw_addr)
               `RSS_OFF_CFG1: begin
                  if (w_strb[0]) begin
                     cfg1 <= w_data[7:0];
                  end
               end
               `RSS_OFF_CFG2: begin
                  if (w_strb[0]) begin
                     cfg2 <= w_data[7:0];
                  end
               end
               `RSS_OFF_BRKAUX: begin
                  if (w_strb[0]) begin
                     brkaux <= w_data[7:0];
                  end
               end
               `RSS_OFF_CAUSE, `RSS_OFF_SERVICE: begin
                  s_axi_bresp <= `RSS_OKAY;
               end
               default: begin
                  s_axi_bresp <= `RSS_SLVERR;
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RSS_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RSS_OKAY;
            case (s_axi_araddr)
               `RSS_OFF_CAUSE: s_axi_rdata <= {24'h000000, cause};
               `RSS_OFF_CFG1: s_axi_rdata <= {24'h000000, cfg1};
               `RSS_OFF_CFG2: s_axi_rdata <= {24'h000000, cfg2};
               `RSS_OFF_BRKAUX: s_axi_rdata <= {24'h000000, brkaux};
               `RSS_OFF_SERVICE: s_axi_rdata <= 32'h00000000;
               `RSS_OFF_STATUS: s_axi_rdata <= {13'h0000, state, prescale, 4'h0};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RSS_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== rss_seq_props.sv
// Concurrent checks on the reset sequencer's ports.
// Assumes a bind from the bench; one clock domain with sync reset.
`timescale 1ns/100ps
`default_nettype none
module rss_seq_props #(
   parameter NUM_IRQ = 8,
   parameter IRQ_IDX_W = 3
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // CPU and interrupt side
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_write,
   input wire logic monitor_mode,
   input wire logic [NUM_IRQ-1:0] irq_req,
   input wire logic int_begin,
   input wire logic int_serviced,
   input wire logic i_mask_cleared,
   input wire logic cpu_rti,
   input wire logic int_latched,
   input wire logic [IRQ_IDX_W-1:0] int_vector_sel,
   input wire logic set_i_mask,
   input wire logic restore_regs,
   // Reset outputs
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic internal_reset_signal,
   input wire logic [15:0] reset_vector,
   input wire logic bus_clk_en,
   input wire logic watchdog_clear
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_vector_select: assert property (
      internal_reset_signal && $past(internal_reset_signal) && $stable(monitor_mode)
      |-> reset_vector == (monitor_mode ? 16'hFEFE : 16'hFFFE)) else $error("bad reset vector");
   a_oe_in_reset: assert property (reset_pin_oe && $past(reset_pin_oe)
      |-> internal_reset_signal) else $error("pin driven outside reset");
   a_drive_low: assert property (reset_pin_oe |-> !reset_pin_out)
      else $error("pin driven high");
   a_reset_span: assert property (
      $rose(internal_reset_signal) |=> internal_reset_signal [*8]) else $error("reset too short");
   a_bus_quarter: assert property (bus_clk_en |=> !bus_clk_en [*3])
      else $error("bus enable faster than one in four");
   a_service_clear: assert property (
      cpu_write && cpu_addr == 16'hFFFF && !internal_reset_signal |-> ##[1:2] watchdog_clear)
      else $error("service write did not clear watchdog");
   a_entry_mask: assert property (
      int_begin && !int_latched && |irq_req && !internal_reset_signal |=> set_i_mask && int_latched)
      else $error("entry did not set mask");
   a_latch_holds: assert property (
      int_latched && !int_serviced && !i_mask_cleared && !internal_reset_signal
      |=> int_latched && $stable(int_vector_sel)) else $error("latched request lost");
   a_rti_restore: assert property (cpu_rti && !internal_reset_signal |=> restore_regs)
      else $error("return did not restore");
endmodule
`default_nettype wire
